// File: common/ldsp_pkg.sv
/*
  Package of the serial display port: widths, command fields, reset
  values, timing counts, scan states and a shared one-hot decode function.
  Assumes a 10 MHz core clock and a host shift clock far slower.
*/
package ldsp_pkg;
  localparam int CMD_W  = 8;   // Command byte width
  localparam int ROW_W  = 56;  // Display row width
  localparam int KEY_W  = 32;  // Key word width
  localparam int ROWS   = 4;   // Output latch rows
  localparam int SRC_N  = 8;   // Key source outputs
  localparam int RET_N  = 4;   // Key return inputs
  localparam int CNT_W  = 7;   // Received bit counter width
  localparam int SYN_W  = 10;  // Synchronised pin inputs

  // Bit counter landmarks
  localparam logic [6:0] CNT_CMD_LAST = 7'h07;
  localparam logic [6:0] CNT_CMD_DONE = 7'h08;
  localparam logic [6:0] CNT_ROW_DONE = 7'h40;

  // Command fields
  localparam int CMD_KIND_HI = 7;
  localparam int CMD_KIND_LO = 6;
  localparam logic [1:0] KIND_SET  = 2'h0;
  localparam logic [1:0] KIND_STAT = 2'h2;
  localparam int STAT_RD_BIT  = 2;
  localparam int STAT_ADR_HI  = 4;
  localparam int STAT_ADR_LO  = 3;
  localparam int STAT_DSP_HI  = 1;
  localparam int STAT_DSP_LO  = 0;
  localparam int SET_SLAVE_BIT = 0;
  localparam logic [1:0] DISP_NORMAL = 2'h2;

  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [1:0] DISP_RST = 2'h0;
  localparam logic [1:0] ADR_RST  = 2'h0;
  // Synchroniser idle levels: returns low, all other pins high
  localparam logic [SYN_W-1:0] SYN_RST = 10'h03F;

  // Timing counts in core cycles
  localparam int FRAME_CYC = 2048;
  localparam int SLOT_CYC  = 16;
  localparam int SYNC_CYC  = 4;

  // Key scan states, Gray from IDLE to DRIVE to DONE, two bits change from DONE back to IDLE
  typedef enum logic [1:0] {
    SC_IDLE  = 2'h0,
    SC_DRIVE = 2'h1,
    SC_DONE  = 2'h3
  } ldsp_scan_t;

  // One-hot decode of a 3-bit index
  function automatic logic [7:0] ldsp_onehot(input logic [2:0] idx);
    ldsp_onehot = 8'h01 << idx;
  endfunction : ldsp_onehot
endpackage : ldsp_pkg

// File: common/ldsp_key_if.sv
/*
  Carrier between the serial port top and its key scanner.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/10ps
interface ldsp_key_if;
  logic       frame_start; // Frame boundary pulse
  logic       scan_en;     // Display in normal operation
  logic       gate_ok;     // Output gate high
  logic [3:0] ret;         // Synchronised return lines
  logic [7:0] src;         // Key source drive
  logic       src_act;     // Scan slot in progress
  logic       key_req;     // Pressed key present
  logic [31:0] word;       // Confirmed key word
  logic       word_valid;  // New key word offered
  logic       word_ready;  // Buffer accepts word

  modport scan (input frame_start, scan_en, gate_ok, ret, word_ready,
                output src, src_act, key_req, word, word_valid);
  modport top  (output frame_start, scan_en, gate_ok, ret, word_ready,
                input src, src_act, key_req, word, word_valid);
endinterface : ldsp_key_if

// File: rtl/ldsp_buf2.sv
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes a single clock and an asynchronous low reset.
*/
`timescale 1ns/10ps
module ldsp_buf2
  import ldsp_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Storage
  logic [PW-1:0]    wp_ff, nxt_wp;   // Write pointer
  logic [PW-1:0]    rp_ff, nxt_rp;   // Read pointer
  logic [PW:0]      cnt_ff, nxt_cnt; // Fill level
  logic             push, pop;

  assign in_ready_o  = (cnt_ff != DEPTH_C);
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rp_ff];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;

  // Pointer and level update
  always_comb begin
    nxt_wp  = push ? PW'(wp_ff + 1'b1) : wp_ff;
    nxt_rp  = pop ? PW'(rp_ff + 1'b1) : rp_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  // Register pointers and level
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage written on push, no reset needed
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wp_ff] <= in_data_i;
    end
  end
endmodule : ldsp_buf2

// File: rtl/ldsp_keyscan.sv
/*
  Key scanner: drives one source per slot, samples the return lines,
  confirms a word when two frames agree and offers it downstream.
  Assumes frame_start pulses once per frame from the port top.
*/
`timescale 1ns/10ps
module ldsp_keyscan
  import ldsp_pkg::*;
#(
  parameter int SLOT_CYCLES = SLOT_CYC
) (
  input  wire logic clock_i,
  input  wire logic nrst_i,
  ldsp_key_if.scan  kif
);
  ldsp_scan_t  st_ff,   nxt_st;   // Scan state
  logic [2:0]  slot_ff, nxt_slot; // Source index
  logic [3:0]  cyc_ff,  nxt_cyc;  // Cycle within slot
  logic [31:0] acc_ff,  nxt_acc;  // This frame's sample
  logic [31:0] prev_ff, nxt_prev; // Previous frame's sample
  logic [31:0] keys_ff, nxt_keys; // Confirmed key word
  logic        pend_ff, nxt_pend; // Word waiting for buffer

  assign kif.src_act    = (st_ff == SC_DRIVE);
  assign kif.src        = kif.src_act ? ldsp_onehot(slot_ff) : 8'h00;
  assign kif.key_req    = |keys_ff;
  assign kif.word       = keys_ff;
  assign kif.word_valid = pend_ff;

  // Scan sequencing and confirmation
  always_comb begin
    nxt_st   = st_ff;
    nxt_slot = slot_ff;
    nxt_cyc  = cyc_ff;
    nxt_acc  = acc_ff;
    nxt_prev = prev_ff;
    nxt_keys = keys_ff;
    nxt_pend = pend_ff && !kif.word_ready;
    case (st_ff)
      SC_IDLE: begin
        // Start a scan at each frame boundary while the display is in normal operation
        if (kif.frame_start && kif.scan_en) begin
          nxt_st   = SC_DRIVE;
          nxt_slot = 3'h0;
          nxt_cyc  = 4'h0;
        end
      end
      SC_DRIVE: begin
        nxt_cyc = cyc_ff + 4'h1;
        if (!kif.scan_en) begin
          nxt_st = SC_IDLE;
        end else if (cyc_ff == 4'(SLOT_CYCLES - 1)) begin
          // Sample the four returns at slot end
          nxt_acc[(7 - slot_ff) * 4 +: 4] = kif.ret;
          nxt_cyc  = 4'h0;
          nxt_slot = slot_ff + 3'h1;
          if (slot_ff == 3'h7) begin
            nxt_st = SC_DONE;
          end
        end
      end
      SC_DONE: begin
        nxt_st   = SC_IDLE;
        nxt_prev = acc_ff;
        // Latch only on two equal frames, never with gate low
        if (acc_ff == prev_ff && kif.gate_ok) begin
          nxt_keys = acc_ff;
          if (acc_ff != keys_ff) begin
            nxt_pend = 1'b1; // Set wins over the buffer take
          end
        end
      end
      default: nxt_st = SC_IDLE;
    endcase
  end

  // Register scan state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_ff   <= SC_IDLE;
      slot_ff <= 3'h0;
      cyc_ff  <= 4'h0;
      acc_ff  <= 32'h0;
      prev_ff <= 32'h0;
      keys_ff <= 32'h0;
      pend_ff <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      slot_ff <= nxt_slot;
      cyc_ff  <= nxt_cyc;
      acc_ff  <= nxt_acc;
      prev_ff <= nxt_prev;
      keys_ff <= nxt_keys;
      pend_ff <= nxt_pend;
    end
  end
endmodule : ldsp_keyscan

// File: rtl/ldsp_port.sv
/*
  Serial host port of a segment display controller with key scanning.
  Holds pin synchronisers, the command and display shift registers,
  command processing, the output latch, frame timing with wired-OR
  frame sync, segment and lamp output staging and key read-back.
  Assumes the host shift clock runs at most an eighth of clock_i.
*/
`timescale 1ns/10ps
module ldsp_port
  import ldsp_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC,
  parameter int SLOT_CYCLES  = SLOT_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        nrst_i,
  input  wire logic        shift_clk_i,
  input  wire logic        transfer_frame_low_i,
  input  wire logic        data_i,
  output logic             data_o,
  output logic             data_oe_o,
  input  wire logic        panel_or_lamp_select_i,
  input  wire logic        out_gate_i,
  input  wire logic [3:0]  return_line_inputs_i,
  input  wire logic        sync_i,
  output logic             sync_o,
  output logic             sync_oe_o,
  output logic [7:0]       scan_source_shared_outputs_o,
  output logic [39:0]      seg_plain_o,
  output logic [7:0]       lamp_capable_outputs_o,
  output logic [7:0]       lamp_sink_oe_o,
  output logic [3:0]       backplane_drives_o,
  output logic             key_request_o
);
  localparam int ROW_CYC = FRAME_CYCLES / ROWS;
  localparam int FW      = $clog2(FRAME_CYCLES);

  // Pin synchroniser stages
  logic [SYN_W-1:0] s1_ff, s2_ff, s3_ff;
  logic [SYN_W-1:0] pins;
  logic sck, stb, din, sel, gate, sync_in;
  logic sck_rise, sck_fall, stb_rise, stb_fall, sync_fall;

  // Serial receive and transmit state
  logic [CNT_W-1:0] cnt_ff,  nxt_cnt;  // Received bit count
  logic [7:0]       cmd_ff,  nxt_cmd;  // command_shift_byte
  logic [55:0]      row_ff,  nxt_row;  // display_shift_row
  logic [31:0]      tx_ff,   nxt_tx;   // Key word being sent
  logic [31:0]      last_ff, nxt_last; // Last word sent
  logic             txon_ff, nxt_txon; // Read transfer active
  logic             low_ff,  nxt_low;  // Pulling data low

  // Configuration and output latch
  logic [7:0]  mode_ff, nxt_mode;      // Display setting byte
  logic [1:0]  disp_ff, nxt_disp;      // Display control field
  logic [1:0]  adr_ff,  nxt_adr;       // Latch address
  logic        rd_ff,   nxt_rd;        // Read mode
  logic [55:0] lat_ff [ROWS];          // Output latch rows
  logic        lat_we;                 // Latch write strobe
  logic [1:0]  lat_adr;                // Latch write row

  // Frame timing
  logic [FW-1:0] frm_ff,  nxt_frm;     // Cycle within frame
  logic [1:0]    rowi_ff, nxt_rowi;    // Active backplane row
  logic [2:0]    syn_ff,  nxt_syn;     // Sync pulse length left
  logic          fstart;               // Frame boundary

  // Output staging
  logic [55:0] lit;                    // Lit segments this row
  logic        disp_on;
  logic [7:0]  src_ff, nxt_src;
  logic [39:0] plain_ff, nxt_plain;
  logic [7:0]  lamp_ff, nxt_lamp;
  logic [7:0]  sink_ff, nxt_sink;
  logic [3:0]  bp_ff, nxt_bp;

  // Buffer draining side
  logic [31:0] buf_data;
  logic        buf_valid, buf_pop;

  ldsp_key_if kif ();

  // Two-flop synchronisers on every pin input
  assign pins = {return_line_inputs_i, sync_i, out_gate_i,
                 panel_or_lamp_select_i, data_i, transfer_frame_low_i,
                 shift_clk_i};
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_ff <= SYN_RST;
      s2_ff <= SYN_RST;
      s3_ff <= SYN_RST;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Levels and edges, all from the second stage onward
  assign sck       = s2_ff[0];
  assign stb       = s2_ff[1];
  assign din       = s2_ff[2];
  assign sel       = s2_ff[3];
  assign gate      = s2_ff[4];
  assign sync_in   = s2_ff[5];
  assign sck_rise  = sck && !s3_ff[0];
  assign sck_fall  = !sck && s3_ff[0];
  assign stb_rise  = stb && !s3_ff[1];
  assign stb_fall  = !stb && s3_ff[1];
  assign sync_fall = !sync_in && s3_ff[5];

  // Serial reception, command processing and key send
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_cmd  = cmd_ff;
    nxt_row  = row_ff;
    nxt_tx   = tx_ff;
    nxt_last = last_ff;
    nxt_txon = txon_ff;
    nxt_low  = low_ff;
    nxt_mode = mode_ff;
    nxt_disp = disp_ff;
    nxt_adr  = adr_ff;
    nxt_rd   = rd_ff;
    lat_we   = 1'b0;
    lat_adr  = adr_ff;
    buf_pop  = 1'b0;
    if (stb) begin
      // Idle between transfers: restart and release the line
      nxt_cnt  = '0;
      nxt_txon = 1'b0;
      nxt_low  = 1'b0;
      if (stb_rise && cnt_ff >= CNT_CMD_DONE) begin
        if (cmd_ff[CMD_KIND_HI:CMD_KIND_LO] == KIND_SET) begin
          // New setting blanks the display and stops scanning
          if (cmd_ff != mode_ff) begin
            nxt_mode = cmd_ff;
            nxt_disp = DISP_RST;
          end
        end else if (cmd_ff[CMD_KIND_HI:CMD_KIND_LO] == KIND_STAT) begin
          nxt_rd   = cmd_ff[STAT_RD_BIT];
          nxt_adr  = cmd_ff[STAT_ADR_HI:STAT_ADR_LO];
          nxt_disp = cmd_ff[STAT_DSP_HI:STAT_DSP_LO];
        end
        // Full row received in write mode goes to the latch
        if (cnt_ff == CNT_ROW_DONE && !nxt_rd) begin
          lat_we  = 1'b1;
          lat_adr = nxt_adr;
        end
      end
    end else if (stb_fall) begin
      nxt_cnt = '0;
    end else begin
      if (sck_rise) begin
        if (cnt_ff < CNT_CMD_DONE) begin
          nxt_cmd = {cmd_ff[6:0], din};
          if (cnt_ff == CNT_CMD_LAST &&
              cmd_ff[6:5] == KIND_STAT &&
              cmd_ff[STAT_RD_BIT - 1]) begin
            // Read command complete: load key word to send
            nxt_txon = 1'b1;
            buf_pop  = buf_valid;
            nxt_tx   = buf_valid ? buf_data : last_ff;
            nxt_last = nxt_tx;
          end
        end else if (cnt_ff < CNT_ROW_DONE && !txon_ff) begin
          nxt_row = {row_ff[54:0], din};
        end
        if (cnt_ff < CNT_ROW_DONE) begin
          nxt_cnt = cnt_ff + 1'b1;
        end
      end
      if (sck_fall && txon_ff) begin
        nxt_low = !tx_ff[31];
        nxt_tx  = {tx_ff[30:0], 1'b0};
      end
    end
  end

  // Register serial and configuration state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_ff  <= '0;
      cmd_ff  <= 8'h00;
      row_ff  <= 56'h0;
      tx_ff   <= 32'h0;
      last_ff <= 32'h0;
      txon_ff <= 1'b0;
      low_ff  <= 1'b0;
      mode_ff <= MODE_RST;
      disp_ff <= DISP_RST;
      adr_ff  <= ADR_RST;
      rd_ff   <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      cmd_ff  <= nxt_cmd;
      row_ff  <= nxt_row;
      tx_ff   <= nxt_tx;
      last_ff <= nxt_last;
      txon_ff <= nxt_txon;
      low_ff  <= nxt_low;
      mode_ff <= nxt_mode;
      disp_ff <= nxt_disp;
      adr_ff  <= nxt_adr;
      rd_ff   <= nxt_rd;
    end
  end

  // Output latch rows
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < ROWS; i++) begin
        lat_ff[i] <= 56'h0;
      end
    end else if (lat_we) begin
      lat_ff[lat_adr] <= row_ff;
    end
  end

  // Open drain data: output low, enable only to pull low
  assign data_o    = 1'b0;
  assign data_oe_o = low_ff;

  // Frame timing with wired-OR sync
  always_comb begin
    fstart   = (frm_ff == FW'(FRAME_CYCLES - 1));
    nxt_frm  = fstart ? '0 : FW'(frm_ff + 1'b1);
    nxt_rowi = rowi_ff;
    nxt_syn  = (syn_ff != 3'h0) ? syn_ff - 3'h1 : 3'h0;
    if (mode_ff[SET_SLAVE_BIT] && sync_fall) begin
      // Followers restart their frame on the shared edge
      nxt_frm  = '0;
      nxt_rowi = 2'h0;
    end else if (fstart) begin
      nxt_rowi = 2'h0;
      if (!mode_ff[SET_SLAVE_BIT]) begin
        nxt_syn = 3'(SYNC_CYC);
      end
    end else if (frm_ff == FW'(ROW_CYC * (32'(rowi_ff) + 1) - 1)) begin
      nxt_rowi = rowi_ff + 2'h1;
    end
  end

  // Register frame timing
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      frm_ff  <= '0;
      rowi_ff <= 2'h0;
      syn_ff  <= 3'h0;
    end else begin
      frm_ff  <= nxt_frm;
      rowi_ff <= nxt_rowi;
      syn_ff  <= nxt_syn;
    end
  end

  // Sync pin only ever pulled low
  assign sync_o    = 1'b0;
  assign sync_oe_o = (syn_ff != 3'h0);

  // Key scanner and its two-entry buffer
  assign kif.frame_start = fstart;
  assign kif.scan_en     = (disp_ff == DISP_NORMAL);
  assign kif.gate_ok     = gate;
  assign kif.ret         = s2_ff[9:6];

  ldsp_keyscan #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_scan (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .kif     (kif)
  );

  ldsp_buf2 #(
    .WIDTH (KEY_W),
    .DEPTH (2)
  ) u_buf (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (kif.word_valid),
    .in_ready_o  (kif.word_ready),
    .in_data_i   (kif.word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop),
    .out_data_o  (buf_data)
  );

  assign key_request_o = kif.key_req;

  // Segment, lamp and backplane staging
  always_comb begin
    disp_on   = (disp_ff == DISP_NORMAL) && gate;
    lit       = disp_on ? lat_ff[rowi_ff] : 56'h0;
    nxt_src   = kif.src_act ? kif.src : lit[7:0];
    nxt_plain = lit[47:8];
    nxt_bp    = disp_on ? 4'(ldsp_onehot({1'b0, rowi_ff})) : 4'h0;
    if (sel) begin
      nxt_lamp = lit[55:48];
      nxt_sink = 8'h00;
    end else begin
      nxt_lamp = 8'h00;
      nxt_sink = disp_on ? ~lat_ff[rowi_ff][55:48] : 8'h00;
    end
  end

  // Register outputs
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      src_ff   <= 8'h00;
      plain_ff <= 40'h0;
      lamp_ff  <= 8'h00;
      sink_ff  <= 8'h00;
      bp_ff    <= 4'h0;
    end else begin
      src_ff   <= nxt_src;
      plain_ff <= nxt_plain;
      lamp_ff  <= nxt_lamp;
      sink_ff  <= nxt_sink;
      bp_ff    <= nxt_bp;
    end
  end

  assign scan_source_shared_outputs_o = src_ff;
  assign seg_plain_o                  = plain_ff;
  assign lamp_capable_outputs_o       = lamp_ff;
  assign lamp_sink_oe_o               = sink_ff;
  assign backplane_drives_o           = bp_ff;
endmodule : ldsp_port

// File: dv/ldsp_host_model.sv
/*
  Host side of the three-wire link: strobe, shift clock and a shared
  data wire with a pull-up. Assumes clock_i is the 10 MHz core clock.
*/
`timescale 1ns/10ps
module ldsp_host_model (
  input  wire logic clock_i,     // Core clock, paces the link
  input  wire logic dev_oe_i,    // Device pulls the wire low
  output logic      shift_clk_o, // Shift clock, idles high
  output logic      frame_low_o, // Strobe, low during a transfer
  output logic      line_o       // Resolved data wire
);
  logic drv = 1'b0; // Host drives the wire
  logic val = 1'b1; // Level the host drives
  initial shift_clk_o = 1'b1;
  initial frame_low_o = 1'b1;
  // Pull-up holds the wire high unless someone pulls it low
  assign line_o = !dev_oe_i && (drv ? val : 1'b1);
  // Half a link period: four core cycles, just after an edge
  task automatic half;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : half
  // One bit: data changes on the fall, held across the rise
  task automatic put(input logic b);
    shift_clk_o = 1'b0;
    val = b;
    half();
    shift_clk_o = 1'b1;
    half();
  endtask : put
  // Close a frame and leave an idle gap
  task automatic close;
    half();
    frame_low_o = 1'b1;
    drv = 1'b0;
    repeat (3) half();
  endtask : close
  // Write: command byte, then n row bits, both MSB first
  task automatic xfer(input logic [7:0] cmd, input logic [55:0] row, input int n);
    frame_low_o = 1'b0;
    drv = 1'b1;
    half();
    for (int i = 7; i >= 0; i--) put(cmd[i]);
    for (int i = 55; i > 55 - n; i--) put(row[i]);
    close();
  endtask : xfer
  // Read: command byte, release the wire, clock 32 bits in
  task automatic rd(input logic [7:0] cmd, output logic [31:0] key);
    frame_low_o = 1'b0;
    drv = 1'b1;
    half();
    for (int i = 7; i >= 0; i--) put(cmd[i]);
    drv = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      shift_clk_o = 1'b0;
      half();
      shift_clk_o = 1'b1;
      half();
      key[i] = line_o; // Taken just before the next fall
    end
    close();
  endtask : rd
endmodule : ldsp_host_model

// File: dv/ldsp_port_asserts.sv
/*
  Pin checker of the serial display port, bound into ldsp_port.
  Assumes a single chip in master mode with sync pulled up.
*/
`timescale 1ns/10ps
module ldsp_port_asserts (
  input wire logic        clock_i,
  input wire logic        nrst_i,
  input wire logic        transfer_frame_low_i,
  input wire logic        panel_or_lamp_select_i,
  input wire logic        out_gate_i,
  input wire logic        data_o,
  input wire logic        data_oe_o,
  input wire logic        sync_oe_o,
  input wire logic [39:0] seg_plain_o,
  input wire logic [7:0]  lamp_capable_outputs_o,
  input wire logic [7:0]  lamp_sink_oe_o,
  input wire logic [3:0]  backplane_drives_o,
  input wire logic        key_request_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // Master sync pulse: four cycles pulled, then released
  sequence s_sync_pulse;
    sync_oe_o [*4] ##1 !sync_oe_o;
  endsequence
  // Gate low long enough to pass the synchroniser
  sequence s_gate_low;
    !out_gate_i [*6];
  endsequence
  a_oe_low_only: assert property (data_oe_o |-> !data_o)
    else $error("Data wire driven high");
  a_oe_release: assert property (transfer_frame_low_i [*8] |-> !data_oe_o)
    else $error("Data wire held outside a transfer");
  a_oe_in_frame: assert property ($rose(data_oe_o) |-> !transfer_frame_low_i)
    else $error("Key bit sent with strobe high");
  a_gate_blank: assert property (s_gate_low |-> seg_plain_o == 40'h0 &&
    lamp_capable_outputs_o == 8'h00 && lamp_sink_oe_o == 8'h00 && backplane_drives_o == 4'h0)
    else $error("Outputs not blanked by gate");
  a_gate_key_hold: assert property (!out_gate_i [*8] |=> $stable(key_request_o))
    else $error("Key state changed with gate low");
  a_panel_no_sink: assert property (panel_or_lamp_select_i [*6] |-> lamp_sink_oe_o == 8'h00)
    else $error("Lamp sinks active in panel mode");
  a_lamp_no_drive: assert property (!panel_or_lamp_select_i [*6] |->
    lamp_capable_outputs_o == 8'h00) else $error("Segments driven in lamp mode");
  a_sync_pulse: assert property ($rose(sync_oe_o) |-> s_sync_pulse)
    else $error("Sync pulse length wrong");
endmodule : ldsp_port_asserts
bind ldsp_port ldsp_port_asserts u_chk (.clock_i, .nrst_i, .transfer_frame_low_i,
  .panel_or_lamp_select_i, .out_gate_i, .data_o, .data_oe_o, .sync_oe_o, .seg_plain_o,
  .lamp_capable_outputs_o, .lamp_sink_oe_o, .backplane_drives_o, .key_request_o);

// File: dv/ldsp_port_test.sv
/*
  Bench of the serial display port: row writes, lamp mode, refused
  short row, output gate and key read-back through the host model.
  Assumes the host model and checker files are compiled first.
*/
`timescale 1ns/10ps
module ldsp_port_test;
  import ldsp_pkg::*;
  localparam logic [55:0] ROW = 56'hC3_0F1E_2D3C_4B5A; // Test row
  logic        clock_i = 1'b0; // Core clock
  logic        nrst_i  = 1'b0; // Reset, low active
  logic        sel     = 1'b1; // Panel or lamp select
  logic        gate    = 1'b1; // Output gate
  logic [3:0]  ret     = 4'h0; // Key return lines
  logic        sck, stb_n, dat; // Host link
  logic        data_oe, sync_oe, req;
  logic [39:0] seg;
  logic [7:0]  lamp, sink, src;
  logic [3:0]  bp;
  logic [31:0] key;
  int          mismatches  = 0;
  int          checks_done = 0;
  // Core clock, 100 ns period
  always #50 clock_i = ~clock_i;
  ldsp_host_model u_host (.clock_i, .dev_oe_i(data_oe), .shift_clk_o(sck),
    .frame_low_o(stb_n), .line_o(dat));
  ldsp_port #(.FRAME_CYCLES(256)) u_dut (.clock_i, .nrst_i, .shift_clk_i(sck),
    .transfer_frame_low_i(stb_n), .data_i(dat), .data_o(), .data_oe_o(data_oe),
    .panel_or_lamp_select_i(sel), .out_gate_i(gate), .return_line_inputs_i(ret),
    .sync_i(!sync_oe), .sync_o(), .sync_oe_o(sync_oe), .scan_source_shared_outputs_o(src),
    .seg_plain_o(seg), .lamp_capable_outputs_o(lamp), .lamp_sink_oe_o(sink),
    .backplane_drives_o(bp), .key_request_o(req));
  // Step n cycles, landing just after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : cyc
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk
  // Wait for backplane row one to start afresh, so checks land early in it
  task automatic wait_row;
    for (int i = 0; i < 600 && bp === 4'h1; i++) cyc(1);
    for (int i = 0; i < 600 && bp !== 4'h1; i++) cyc(1);
    cyc(2);
  endtask : wait_row
  // Wait for the key request to reach a level
  task automatic wait_req(input logic lvl);
    for (int i = 0; i < 3000 && req !== lvl; i++) cyc(1);
  endtask : wait_req
  // Verdict and end of run
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    cyc(6);
    nrst_i = 1'b1;
    cyc(10);
    u_host.xfer(8'h82, ROW, 56);
    wait_row();
    chk(seg, ROW[47:8], "panel segments");
    chk(src, 64'h1, "key source in first scan slot");
    chk(lamp, ROW[55:48], "panel lamp outputs");
    sel = 1'b0;
    cyc(8);
    wait_row();
    chk(sink, 64'h3C, "lamp sinks");
    chk(lamp, 64'h0, "lamp mode drive");
    sel = 1'b1;
    $display("Test row write done");
    u_host.xfer(8'h82, 56'h0, 20);
    wait_row();
    chk(seg, ROW[47:8], "short row kept");
    gate = 1'b0;
    cyc(8);
    chk({seg, bp}, 64'h0, "gate blank");
    gate = 1'b1;
    wait_row();
    chk(seg, ROW[47:8], "data kept over gate");
    $display("Test gate done");
    ret = 4'h5;
    wait_req(1'b1);
    chk(req, 64'h1, "key request raised");
    u_host.rd(8'h86, key);
    chk(key, 64'h5555_5555, "key word");
    ret = 4'h0;
    wait_req(1'b0);
    chk(req, 64'h0, "key request dropped");
    $display("Test key read done");
    report_and_stop();
  end
  // Watchdog, well past the expected run
  initial begin
    #5_000_000;
    mismatches++;
    $display("MISMATCH at %0t: timeout", $time);
    report_and_stop();
  end
endmodule : ldsp_port_test
